// File: fpc_pkg.sv
// How it works
// - build has either two or four counters
// - quadrature only in two-counter build
// - five modes: total, freq, width, period, quad
// - four inputs routed to counters by configuration
// - each counter value readable as measurement word
// - disable freezes counting and accumulator
// - clear zeroes accumulator, not in freq/period
// - preload loads value, not in freq/period
// - latch copies count, holds until next strobe
// - trigger polarity: high, low, falling, rising
// - quadrature counts every edge of both inputs
// - frequency mode accumulator holds hertz
// - totalizer counts rising edges of input
package fpc_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_US = 1;
	localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam logic [3:0] TICK_LAST = 4'(TICK_CYC - 1);
	localparam int WIN_UNIT_US_DEF = 1000;
	// register map, address fields: area, word offset, latch page, word index
	localparam logic [1:0] AREA_CNT = 2'h0;
	localparam logic [1:0] OFS_CFG = 2'h0;
	localparam logic [1:0] OFS_SF = 2'h1;
	localparam logic [1:0] OFS_PRE = 2'h2;
	localparam logic [1:0] OFS_MEAS = 2'h3;
	localparam logic [3:0] PAGE_LATCH = 4'h4;
	localparam logic [5:0] IDX_STATUS = 6'h14;
	// counter configuration word
	localparam int CFG_EN = 0;
	localparam int CFG_MODE = 1;
	localparam int CFG_SUB = 4;
	localparam int CFG_IN1 = 6;
	localparam int CFG_IN2 = 8;
	localparam int CFG_IN2EN = 10;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	// special function word: five fields of enable, polarity, source
	localparam int SF_W = 5;
	localparam int SF_DIS = 0;
	localparam int SF_CLR = 1;
	localparam int SF_PRE = 2;
	localparam int SF_LAT = 3;
	localparam int SF_MRK = 4;
	localparam logic [1:0] POL_HIGH = 2'h0;
	localparam logic [1:0] POL_LOW = 2'h1;
	localparam logic [1:0] POL_FALL = 2'h2;
	localparam logic [1:0] POL_RISE = 2'h3;
	// modes and sub-modes
	localparam logic [2:0] MODE_TOT = 3'h0;
	localparam logic [2:0] MODE_FREQ = 3'h1;
	localparam logic [2:0] MODE_WIDTH = 3'h2;
	localparam logic [2:0] MODE_PERIOD = 3'h3;
	localparam logic [2:0] MODE_QUAD = 3'h4;
	localparam logic [1:0] TOT_UP = 2'h0;
	localparam logic [1:0] TOT_DOWN = 2'h1;
	localparam logic [1:0] TOT_UPDOWN = 2'h2;
	localparam logic [1:0] TOT_CLKDIR = 2'h3;
	// status word bits
	localparam int ST_FOUR = 0;
	localparam int ST_QUAD = 1;
	localparam int ST_STEP = 2;
	localparam int ST_LVL = 4;
	localparam int ST_PEND = 8;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} fpc_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} fpc_wb_rsp_t;

	typedef struct packed {
		logic [3:0][31:0] mem;
		logic [31:0] rd;
	} fpc_mem_t;

	typedef struct packed {
		logic [3:0] in_s1;
		logic [3:0] in_s2;
		logic [3:0] in_prev;
		logic [3:0] tick_div;
		logic tick;
		logic [3:0][31:0] cfg;
		logic [3:0][31:0] sf;
		logic [3:0][31:0] acc;
		logic [3:0][31:0] latch;
		logic [3:0][31:0] tim;
		logic [3:0][19:0] win;
		logic [3:0] armed;
		logic [3:0] pre_pend;
		logic [1:0] scan;
		logic [1:0] rd_idx;
		logic rd_bus;
		logic rd_wait;
		fpc_wb_rsp_t wb;
	} fpc_state_t;
endpackage : fpc_pkg

// File: fpc_preload_mem.sv
`timescale 1ns/1ps
// preload values, one word per counter, registered read port
module fpc_preload_mem (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [1:0] wr_idx,
	input wire logic [3:0] wr_sel,
	input wire logic [31:0] wr_data,
	input wire logic [1:0] rd_idx,
	output logic [31:0] rd_data
);
	fpc_pkg::fpc_mem_t m_reg;
	fpc_pkg::fpc_mem_t m_next;

	// byte lanes written alone so a narrow store keeps the other lanes
	always_comb begin
		m_next = m_reg;
		for (int b = 0; b < 4; b++) begin
			if (wr_en && wr_sel[b]) begin
				m_next.mem[wr_idx][b*8 +: 8] = wr_data[b*8 +: 8];
			end
		end
		m_next.rd = m_reg.mem[rd_idx];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			m_reg <= '0;
		end else begin
			m_reg <= m_next;
		end
	end

	assign rd_data = m_reg.rd;
endmodule : fpc_preload_mem

// File: fpc_core.sv
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
// fast pulse counter unit with classic wishbone register slave
module fpc_core #(
	parameter bit FOUR_CNT = 1'b0,
	parameter int unsigned WIN_UNIT_US = fpc_pkg::WIN_UNIT_US_DEF
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [3:0] PULSE_IN,
	input wire fpc_pkg::fpc_wb_req_t WB_I,
	output fpc_pkg::fpc_wb_rsp_t WB_O
);
	// the build is fixed at elaboration, so the two layouts never coexist
	localparam logic [2:0] NCNT = FOUR_CNT ? 3'h4 : 3'h2;
	localparam bit QUAD_OK = !FOUR_CNT;
	localparam logic [1:0] STEP_OUTS = FOUR_CNT ? 2'h1 : 2'h2;

	fpc_pkg::fpc_state_t s_reg;
	fpc_pkg::fpc_state_t s_next;

	logic [3:0] rise;
	logic [3:0] fall;
	logic hit;
	logic [1:0] blk;
	logic [1:0] ofs;
	logic cnt_area;
	logic [31:0] wmask;
	logic [31:0] rdv;
	logic mem_we;
	logic [1:0] mem_rd_idx;
	logic [31:0] mem_rd_data;
	logic [2:0] mode;
	logic [1:0] sub;
	logic [1:0] sel1;
	logic [1:0] sel2;
	logic r1;
	logic r2;
	logic ch1;
	logic ch2;
	logic lvl;
	logic dis;
	logic clr;
	logic pre;
	logic lat;
	logic mrk;
	logic may_load;
	logic apply;
	logic up;
	logic [31:0] wlen;

	// byte enables to a bit mask, shared by the configuration and special function words
	function automatic logic [31:0] sel_mask(input logic [3:0] sel);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{sel[b]}};
		end
		return m;
	endfunction : sel_mask

	// trigger of one special function from its enable, polarity and source
	function automatic logic sf_fire(input logic [31:0] w, input int k, input logic [3:0] l,
		input logic [3:0] re, input logic [3:0] fe);
		logic [1:0] pol;
		logic [1:0] src;
		logic t;
		pol = w[k*fpc_pkg::SF_W + 1 +: 2];
		src = w[k*fpc_pkg::SF_W + 3 +: 2];
		unique case (pol)
			fpc_pkg::POL_HIGH: t = l[src];
			fpc_pkg::POL_LOW: t = ~l[src];
			fpc_pkg::POL_FALL: t = fe[src];
			fpc_pkg::POL_RISE: t = re[src];
		endcase
		return w[k*fpc_pkg::SF_W] & t;
	endfunction : sf_fire

	// frequency window length in microsecond ticks, longest at sub 0, shortest at sub 3
	function automatic logic [31:0] win_len(input logic [1:0] sb);
		logic [31:0] f;
		unique case (sb)
			2'h0: f = 32'h0000_03E8;
			2'h1: f = 32'h0000_0064;
			2'h2: f = 32'h0000_000A;
			2'h3: f = 32'h0000_0001;
		endcase
		return 32'(WIN_UNIT_US * f);
	endfunction : win_len

	fpc_preload_mem u_pre (
		.clk(MCLK),
		.rst(RST),
		.wr_en(mem_we),
		.wr_idx(blk),
		.wr_sel(WB_I.sel),
		.wr_data(WB_I.dat),
		.rd_idx(mem_rd_idx),
		.rd_data(mem_rd_data)
	);

	always_comb begin
		s_next = s_reg;
		// two-stage sync, then edge detect on the second stage only
		s_next.in_s1 = PULSE_IN;
		s_next.in_s2 = s_reg.in_s1;
		s_next.in_prev = s_reg.in_s2;
		rise = s_reg.in_s2 & ~s_reg.in_prev;
		fall = ~s_reg.in_s2 & s_reg.in_prev;

		// one microsecond enable from the system clock
		s_next.tick = (s_reg.tick_div == fpc_pkg::TICK_LAST);
		s_next.tick_div = s_next.tick ? 4'h0 : s_reg.tick_div + 4'h1;

		// bus decode; one request per ack, ack drops the next cycle
		hit = WB_I.cyc & WB_I.stb & ~s_reg.wb.ack;
		blk = WB_I.adr[5:4];
		ofs = WB_I.adr[3:2];
		cnt_area = (WB_I.adr[7:6] == fpc_pkg::AREA_CNT) && ({1'b0, blk} < NCNT);
		wmask = sel_mask(WB_I.sel);
		mem_we = 1'b0;
		mem_rd_idx = s_reg.scan;
		s_next.rd_bus = 1'b0;
		s_next.wb.ack = 1'b0;
		rdv = 32'h0000_0000;
		if (cnt_area) begin
			unique case (ofs)
				fpc_pkg::OFS_CFG: rdv = s_reg.cfg[blk];
				fpc_pkg::OFS_SF: rdv = s_reg.sf[blk];
				fpc_pkg::OFS_PRE: rdv = mem_rd_data;
				fpc_pkg::OFS_MEAS: rdv = s_reg.acc[blk];
			endcase
		end else if (WB_I.adr[7:4] == fpc_pkg::PAGE_LATCH && {1'b0, WB_I.adr[3:2]} < NCNT) begin
			rdv = s_reg.latch[WB_I.adr[3:2]];
		end else if (WB_I.adr[7:2] == fpc_pkg::IDX_STATUS) begin
			rdv[fpc_pkg::ST_FOUR] = FOUR_CNT;
			rdv[fpc_pkg::ST_QUAD] = QUAD_OK;
			rdv[fpc_pkg::ST_STEP +: 2] = STEP_OUTS;
			rdv[fpc_pkg::ST_LVL +: 4] = s_reg.in_s2;
			rdv[fpc_pkg::ST_PEND +: 4] = s_reg.pre_pend;
		end
		if (hit) begin
			if (cnt_area && ofs == fpc_pkg::OFS_PRE && !WB_I.we && !s_reg.rd_wait) begin
				// preload readback waits one cycle for the memory port
				mem_rd_idx = blk;
				s_next.rd_bus = 1'b1;
				s_next.rd_wait = 1'b1;
			end else begin
				s_next.wb.ack = 1'b1;
				s_next.wb.dat = WB_I.we ? 32'h0000_0000 : rdv;
				s_next.rd_wait = 1'b0;
				if (WB_I.we && cnt_area) begin
					unique case (ofs)
						fpc_pkg::OFS_CFG: begin
							s_next.cfg[blk] = (s_reg.cfg[blk] & ~wmask) | (WB_I.dat & wmask);
							s_next.armed[blk] = 1'b0;
							s_next.tim[blk] = 32'h0000_0000;
							s_next.win[blk] = 20'h0_0000;
						end
						fpc_pkg::OFS_SF: s_next.sf[blk] = (s_reg.sf[blk] & ~wmask) | (WB_I.dat & wmask);
						fpc_pkg::OFS_PRE: mem_we = 1'b1;
						fpc_pkg::OFS_MEAS: ;
					endcase
				end
			end
		end
		// the scan walks the preload words whenever the bus leaves the port free
		s_next.rd_idx = mem_rd_idx;
		if (!s_next.rd_bus) begin
			s_next.scan = s_reg.scan + 2'h1;
		end

		mode = '0;
		sub = '0;
		sel1 = '0;
		sel2 = '0;
		r1 = 1'b0;
		r2 = 1'b0;
		ch1 = 1'b0;
		ch2 = 1'b0;
		lvl = 1'b0;
		dis = 1'b0;
		clr = 1'b0;
		pre = 1'b0;
		lat = 1'b0;
		mrk = 1'b0;
		may_load = 1'b0;
		apply = 1'b0;
		up = 1'b0;
		wlen = '0;
		for (int i = 0; i < 4; i++) begin
			// counters above the build size stay idle and read as unmapped
			if (i < int'(NCNT) && s_reg.cfg[i][fpc_pkg::CFG_EN]) begin
				mode = s_reg.cfg[i][fpc_pkg::CFG_MODE +: 3];
				sub = s_reg.cfg[i][fpc_pkg::CFG_SUB +: 2];
				sel1 = s_reg.cfg[i][fpc_pkg::CFG_IN1 +: 2];
				sel2 = s_reg.cfg[i][fpc_pkg::CFG_IN2 +: 2];
				r1 = rise[sel1];
				r2 = rise[sel2] & s_reg.cfg[i][fpc_pkg::CFG_IN2EN];
				ch1 = rise[sel1] | fall[sel1];
				ch2 = rise[sel2] | fall[sel2];
				dis = sf_fire(s_reg.sf[i], fpc_pkg::SF_DIS, s_reg.in_s2, rise, fall);
				clr = sf_fire(s_reg.sf[i], fpc_pkg::SF_CLR, s_reg.in_s2, rise, fall);
				pre = sf_fire(s_reg.sf[i], fpc_pkg::SF_PRE, s_reg.in_s2, rise, fall);
				lat = sf_fire(s_reg.sf[i], fpc_pkg::SF_LAT, s_reg.in_s2, rise, fall);
				mrk = sf_fire(s_reg.sf[i], fpc_pkg::SF_MRK, s_reg.in_s2, rise, fall);
				may_load = (mode != fpc_pkg::MODE_FREQ) && (mode != fpc_pkg::MODE_PERIOD);
				// latch works even while disabled; it holds until the next strobe
				if (lat) begin
					s_next.latch[i] = s_reg.acc[i];
				end
				apply = ~s_reg.rd_bus && (s_reg.rd_idx == 2'(i)) && s_reg.pre_pend[i] && !dis;
				// a new trigger in the apply cycle wins and stays pending
				s_next.pre_pend[i] = (s_reg.pre_pend[i] & ~apply) | (pre & may_load);
				if (dis) begin
					// frozen: accumulator and timers untouched
					s_next.acc[i] = s_reg.acc[i];
				end else if (clr && may_load) begin
					s_next.acc[i] = 32'h0000_0000;
				end else if (mrk && mode == fpc_pkg::MODE_QUAD && QUAD_OK) begin
					s_next.acc[i] = 32'h0000_0000;
				end else if (apply) begin
					s_next.acc[i] = mem_rd_data;
				end else begin
					unique case (mode)
						fpc_pkg::MODE_TOT: begin
							unique case (sub)
								fpc_pkg::TOT_UP: if (r1 | r2) s_next.acc[i] = s_reg.acc[i] + 32'h1;
								fpc_pkg::TOT_DOWN: if (r1 | r2) s_next.acc[i] = s_reg.acc[i] - 32'h1;
								fpc_pkg::TOT_UPDOWN: begin
									if (r1 && !r2) s_next.acc[i] = s_reg.acc[i] + 32'h1;
									else if (r2 && !r1) s_next.acc[i] = s_reg.acc[i] - 32'h1;
								end
								fpc_pkg::TOT_CLKDIR: begin
									if (r1) begin
										s_next.acc[i] = s_reg.in_s2[sel2] ? s_reg.acc[i] - 32'h1
											: s_reg.acc[i] + 32'h1;
									end
								end
							endcase
						end
						fpc_pkg::MODE_FREQ: begin
							// edges counted over a window, scaled to cycles per second
							wlen = win_len(sub);
							s_next.tim[i] = s_reg.tim[i] + 32'(r1);
							if (s_reg.tick) begin
								if ({12'h000, s_reg.win[i]} >= wlen - 32'h1) begin
									s_next.acc[i] = 32'(s_next.tim[i] * (32'h000F_4240 / wlen));
									s_next.tim[i] = 32'h0000_0000;
									s_next.win[i] = 20'h0_0000;
								end else begin
									s_next.win[i] = s_reg.win[i] + 20'h1;
								end
							end
						end
						fpc_pkg::MODE_WIDTH: begin
							// sub 0 measures high time, sub 1 low time, in microseconds
							lvl = s_reg.in_s2[sel1] ^ sub[0];
							if (lvl && (sub[0] ? fall[sel1] : rise[sel1])) begin
								s_next.armed[i] = 1'b1;
								s_next.tim[i] = 32'h0000_0000;
							end else if (!lvl && s_reg.armed[i] && (sub[0] ? rise[sel1] : fall[sel1])) begin
								s_next.acc[i] = s_reg.tim[i];
								s_next.tim[i] = 32'h0000_0000;
							end else if (lvl && s_reg.armed[i] && s_reg.tick) begin
								s_next.tim[i] = s_reg.tim[i] + 32'h1;
							end
						end
						fpc_pkg::MODE_PERIOD: begin
							// a tick in the edge cycle is dropped: up to 1 us short
							if (sub[0] ? fall[sel1] : rise[sel1]) begin
								if (s_reg.armed[i]) s_next.acc[i] = s_reg.tim[i];
								s_next.armed[i] = 1'b1;
								s_next.tim[i] = 32'h0000_0000;
							end else if (s_reg.armed[i] && s_reg.tick) begin
								s_next.tim[i] = s_reg.tim[i] + 32'h1;
							end
						end
						fpc_pkg::MODE_QUAD: begin
							// exactly one channel moved: one count per edge, four per cycle
							if (QUAD_OK && (ch1 ^ ch2)) begin
								up = ~(s_reg.in_prev[sel1] ^ s_reg.in_s2[sel2]) ^ sub[0];
								s_next.acc[i] = up ? s_reg.acc[i] + 32'h1 : s_reg.acc[i] - 32'h1;
							end
						end
						default: ;
					endcase
				end
			end
		end
	end

	// all state cleared by reset, counters come up disabled
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign WB_O = s_reg.wb;
endmodule : fpc_core

// File: fpc_core_sva.sv
`timescale 1ns/1ps
// bus timing and status checks seen from the top ports only
module fpc_sva #(
	parameter bit FOUR_CNT = 1'b0
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire fpc_pkg::fpc_wb_req_t WB_I,
	input wire fpc_pkg::fpc_wb_rsp_t WB_O
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);
	// a request is pending until its ack, so the late preload answer is not mistaken for a fresh one
	wire logic req = WB_I.cyc && WB_I.stb && !WB_O.ack;
	wire logic rd = WB_O.ack && !WB_I.we;
	// preload words of the counters that this build really has
	wire logic pre_rd = req && !WB_I.we && WB_I.adr[7:6] == 2'h0 && (FOUR_CNT || !WB_I.adr[5])
		&& WB_I.adr[3:0] == 4'h8;
	sequence s_late_ack;
		!WB_O.ack ##1 WB_O.ack;
	endsequence
	sequence s_first_pre;
		pre_rd && !$past(pre_rd);
	endsequence
	ack_one_cycle_a: assert property (WB_O.ack |=> !WB_O.ack) else $error("ack held too long");
	ack_has_cause_a: assert property (WB_O.ack |-> $past(WB_I.cyc && WB_I.stb)) else $error("ack without request");
	fast_ack_a: assert property (req && !pre_rd |=> WB_O.ack) else $error("ack not next cycle");
	slow_ack_a: assert property (s_first_pre |=> s_late_ack) else $error("preload read ack timing");
	write_dat_zero_a: assert property (WB_O.ack && WB_I.we |-> WB_O.dat == 32'h0) else $error("write data not zero");
	unmapped_zero_a: assert property (rd && (WB_I.adr > 8'h53 || (!FOUR_CNT && WB_I.adr[7:5] == 3'h1))
		|-> WB_O.dat == 32'h0) else $error("unmapped read not zero");
	status_build_a: assert property (rd && WB_I.adr == 8'h50 |-> WB_O.dat[3:0] == (FOUR_CNT ? 4'h5 : 4'hA))
		else $error("build bits wrong");
	reset_quiet_a: assert property ($fell(RST) |-> !WB_O.ack && WB_O.dat == 32'h0) else $error("bus busy after reset");
endmodule : fpc_sva
bind fpc_core fpc_sva #(.FOUR_CNT(FOUR_CNT)) u_sva (.MCLK(MCLK), .RST(RST), .WB_I(WB_I), .WB_O(WB_O));

// File: fpc_enc.sv
`timescale 1ns/1ps
// encoder model: one gray step per strobe, lines stand still between steps
module fpc_enc (
	input wire logic clk,
	input wire logic step,
	input wire logic up,
	output logic a,
	output logic b,
	output logic z
);
	logic [1:0] ph_reg = 2'h0;
	logic [3:0] pos_reg = 4'h0;
	// phase and shaft position move together
	always @(posedge clk) begin
		if (step) begin
			ph_reg <= up ? ph_reg + 2'h1 : ph_reg - 2'h1;
			pos_reg <= up ? pos_reg + 4'h1 : pos_reg - 4'h1;
		end
	end
	// gray order keeps the channels a quarter period apart; b leads when turning up
	assign a = ph_reg[1];
	assign b = ph_reg[1] ^ ph_reg[0];
	// one reference position per sixteen steps
	assign z = pos_reg == 4'h0;
endmodule : fpc_enc

// File: fpc_core_tb.sv
`timescale 1ns/1ps
// self-checking bench: counter 0 totalizes, counter 1 follows the encoder
module fpc_core_tb;
	logic MCLK;
	logic RST;
	logic tot;
	logic trig;
	logic enc_a;
	logic enc_b;
	logic step;
	logic up;
	fpc_pkg::fpc_wb_req_t wb_i;
	fpc_pkg::fpc_wb_rsp_t wb_o;
	int num_errors;
	int comparisons;
	int seed;
	int acc0;
	int acc1;
	int held;
	int n;
	logic [31:0] q;
	logic [31:0] v;
	// small window unit keeps frequency windows short
	fpc_core #(.FOUR_CNT(1'b0), .WIN_UNIT_US(2)) dut (.MCLK(MCLK), .RST(RST),
		.PULSE_IN({trig, enc_a, enc_b, tot}), .WB_I(wb_i), .WB_O(wb_o));
	fpc_enc enc (.clk(MCLK), .step(step), .up(up), .a(enc_a), .b(enc_b), .z());
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	// one classic cycle; ack sampled at the rising edge, request dropped right after that edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		wb_i <= '{1'b1, 1'b1, w, a, 4'hF, d};
		do @(posedge MCLK); while (wb_o.ack !== 1'b1);
		r = wb_o.dat;
		wb_i <= '0;
		@(posedge MCLK);
	endtask : bus
	// regular pulse train on line 0, high and low times in clock cycles
	task automatic train(input int hi, input int lo, input int cnt);
		repeat (cnt) begin
			tot <= 1'b1;
			repeat (hi) @(posedge MCLK);
			tot <= 1'b0;
			repeat (lo) @(posedge MCLK);
		end
	endtask : train
	// pulses slow enough for the synchroniser and the preload scan
	task automatic tog(input int i, input int cnt);
		repeat (cnt) begin
			@(posedge MCLK);
			if (i == 0) tot <= 1'b1; else trig <= 1'b1;
			repeat (4) @(posedge MCLK);
			if (i == 0) tot <= 1'b0; else trig <= 1'b0;
			repeat (10) @(posedge MCLK);
		end
	endtask : tog
	task automatic turn(input logic dir, input int cnt);
		repeat (cnt) begin
			@(posedge MCLK);
			up <= dir;
			step <= 1'b1;
			@(posedge MCLK);
			step <= 1'b0;
			repeat (8) @(posedge MCLK);
		end
	endtask : turn
	task automatic report_and_stop;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	initial begin
		MCLK = 1'b0;
		forever #50 MCLK = ~MCLK;
	end
	// whole run needs a few thousand cycles
	initial begin
		repeat (20000) @(posedge MCLK);
		num_errors++;
		report_and_stop();
	end
	initial begin
		num_errors = 0;
		comparisons = 0;
		seed = 32'h3b059bab;
		RST = 1'b1;
		tot = 1'b0;
		trig = 1'b0;
		step = 1'b0;
		up = 1'b0;
		wb_i = '0;
		repeat (5) @(posedge MCLK);
		RST <= 1'b0;
		bus(1'b0, 8'h50, 32'h0, q);
		chk("status", {28'h0, q[3:0]}, 32'hA);
		bus(1'b0, 8'h00, 32'h0, q);
		chk("cfg0", q, 32'h0);
		$display("test reset done");
		// totalizer up on line 0, then frozen by a high level on line 3
		bus(1'b1, 8'h00, 32'h1, q);
		n = ($random(seed) & 7) + 1;
		tog(0, n);
		acc0 = n;
		bus(1'b0, 8'h0C, 32'h0, q);
		chk("tot", q, 32'(acc0));
		bus(1'b1, 8'h04, 32'h19, q);
		@(posedge MCLK);
		trig <= 1'b1;
		tog(0, 3);
		bus(1'b0, 8'h0C, 32'h0, q);
		chk("frozen", q, 32'(acc0));
		trig <= 1'b0;
		// latch on rising line 3 keeps its copy while counting goes on
		bus(1'b1, 8'h04, 32'hF8000, q);
		tog(3, 1);
		held = acc0;
		n = ($random(seed) & 7) + 1;
		tog(0, n);
		acc0 = acc0 + n;
		bus(1'b0, 8'h40, 32'h0, q);
		chk("latch", q, 32'(held));
		bus(1'b0, 8'h0C, 32'h0, q);
		chk("tot2", q, 32'(acc0));
		$display("test totalizer done");
		// clear on rising edge, preload on falling edge
		bus(1'b1, 8'h04, 32'h3E0, q);
		tog(3, 1);
		acc0 = 0;
		bus(1'b0, 8'h0C, 32'h0, q);
		chk("clear", q, 32'(acc0));
		v = $random(seed);
		bus(1'b1, 8'h08, v, q);
		bus(1'b0, 8'h08, 32'h0, q);
		chk("prewd", q, v);
		bus(1'b1, 8'h04, 32'h7400, q);
		tog(3, 1);
		acc0 = v;
		bus(1'b0, 8'h0C, 32'h0, q);
		chk("preload", q, 32'(acc0));
		bus(1'b0, 8'h40, 32'h0, q);
		chk("latch2", q, 32'(held));
		// read-only and unmapped places
		bus(1'b1, 8'h0C, $random(seed), q);
		bus(1'b0, 8'h0C, 32'h0, q);
		chk("ro", q, 32'(acc0));
		bus(1'b0, 8'h60, 32'h0, q);
		chk("unmap", q, 32'h0);
		bus(1'b0, 8'h30, 32'h0, q);
		chk("cnt3", q, 32'h0);
		$display("test special done");
		// quadrature: every edge of both lines counts, direction from phase
		bus(1'b1, 8'h10, 32'h649, q);
		n = ($random(seed) & 15) + 2;
		turn(1'b1, n);
		acc1 = n;
		bus(1'b0, 8'h1C, 32'h0, q);
		chk("quad_up", q, 32'(acc1));
		// marker on rising line 3 zeroes the quadrature count
		bus(1'b1, 8'h14, 32'h01F0_0000, q);
		tog(3, 1);
		acc1 = 0;
		bus(1'b0, 8'h1C, 32'h0, q);
		chk("marker", q, 32'(acc1));
		turn(1'b0, n / 2);
		acc1 = acc1 - n / 2;
		bus(1'b0, 8'h1C, 32'h0, q);
		chk("quad_dn", q, 32'(acc1));
		$display("test quadrature done");
		// reset in mid-run wipes counts and copies
		@(posedge MCLK);
		RST <= 1'b1;
		repeat (2) @(posedge MCLK);
		RST <= 1'b0;
		bus(1'b0, 8'h0C, 32'h0, q);
		chk("rst_acc", q, 32'h0);
		bus(1'b0, 8'h40, 32'h0, q);
		chk("rst_lat", q, 32'h0);
		bus(1'b0, 8'h1C, 32'h0, q);
		chk("rst_q", q, 32'h0);
		$display("test reset again done");
		// width and period in whole microseconds; spans chosen so tick phase cannot matter
		bus(1'b1, 8'h00, 32'h5, q);
		train(51, 50, 2);
		bus(1'b0, 8'h0C, 32'h0, q);
		chk("width", q, 32'(51 * 100 / 1000));
		bus(1'b1, 8'h00, 32'h7, q);
		train(51, 50, 3);
		bus(1'b0, 8'h0C, 32'h0, q);
		chk("period", q, 32'((51 + 50) * 100 / 1000));
		// clear is not offered in period mode, the measurement stays
		bus(1'b1, 8'h04, 32'h3E0, q);
		tog(3, 1);
		bus(1'b0, 8'h0C, 32'h0, q);
		chk("per_clr", q, 32'((51 + 50) * 100 / 1000));
		// frequency read mid-train, after one whole window lies inside the pulses
		bus(1'b1, 8'h00, 32'h23, q);
		fork
			train(10, 10, 40);
			begin
				repeat (500) @(posedge MCLK);
				bus(1'b0, 8'h0C, 32'h0, q);
			end
		join
		chk("freq", q, 32'(1_000_000_000 / ((10 + 10) * 100)));
		$display("test modes done");
		report_and_stop();
	end
endmodule : fpc_core_tb
